// *** hdl/dms_pkg.sv ***
// Package: command codes, mode-register fields and timing counts for the DLL mode switch
package dms_pkg;
    // Command encoding {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_NOP  = 4'h7;
    localparam logic [3:0] CMD_MRS  = 4'h0;
    localparam logic [3:0] CMD_REF  = 4'h1;
    localparam logic [3:0] CMD_ZQ   = 4'h6;
    localparam logic [3:0] CMD_DES  = 4'hF;
    localparam logic [3:0] CMD_RD   = 4'h5;
    localparam logic [3:0] CMD_WR   = 4'h4;
    // Mode register selects on the bank address
    localparam logic [2:0] MR_LAT   = 3'h0;
    localparam logic [2:0] MR_EXT   = 3'h1;
    localparam logic [2:0] MR_CWL   = 3'h2;
    // Field positions
    localparam int DLL_DIS_BIT  = 0;
    localparam int DLL_RST_BIT  = 8;
    localparam int RTT_BIT0     = 2;
    localparam int RTT_BIT1     = 6;
    localparam int RTT_BIT2     = 9;
    localparam int CL_LSB       = 4;
    localparam int CWL_LSB      = 3;
    // DLL-off latency codes (CL 6, CWL 6)
    localparam logic [2:0] CL6_CODE  = 3'h2;
    localparam logic [2:0] CWL6_CODE = 3'h1;
    localparam logic [12:0] MR_RESET = 13'h0000;
    // Timing, controller clock 50 ns
    localparam int CLK_PS       = 50000;
    localparam int TMRD_NCK     = 4;
    localparam int TMOD_NCK     = 12;
    localparam int TCKSRE_NCK   = 5;
    localparam int TCKSRX_NCK   = 5;
    localparam int TXS_NS       = 170;
    localparam int TXS_NCK      = (TXS_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int TDLLK_NCK    = 512;
    localparam int TZQOPER_NCK  = 256;
    localparam int CNT_W        = 10;
endpackage

// *** hdl/dms_link_if.sv ***
// Interface: command, clock-enable and termination pins between controller and memory
`timescale 1ns/1ps
interface dms_link_if;
    logic        cke;
    logic        odt;
    logic [3:0]  cmd;
    logic [2:0]  ba;
    logic [12:0] addr;
    logic        clk_change;
    modport ctrl (output cke, output odt, output cmd, output ba, output addr, output clk_change);
    modport mem  (input cke, input odt, input cmd, input ba, input addr, input clk_change);
endinterface

// *** hdl/dms_mem.sv ***
// Memory end: mode registers, DLL state and next-command readiness
`timescale 1ns/1ps
module dms_mem
    import dms_pkg::*;
(
    input  wire logic  mclk_i,
    input  wire logic  rst_n_i,
    dms_link_if.mem    link,
    output logic       dll_off_o,
    output logic       dll_locked_o,
    output logic       self_ref_o,
    output logic       ready_o,
    output logic [2:0] cl_code_o,
    output logic [2:0] cwl_code_o
);
    logic [12:0]      mr_ext;
    logic [CNT_W-1:0] mod_cnt;
    logic [CNT_W-1:0] lock_cnt;
    logic             cmd_mrs;

    assign cmd_mrs = link.cke && link.cmd == CMD_MRS;

    ////////////////////////////////////////////////////////////////
    // Mode registers
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mr_ext     <= MR_RESET;
            cl_code_o  <= 3'h0;
            cwl_code_o <= 3'h0;
        end else if (cmd_mrs) begin
            if (link.ba == MR_EXT) begin
                mr_ext <= link.addr;
            end
            if (link.ba == MR_LAT) begin
                cl_code_o <= link.addr[CL_LSB +: 3];
            end
            if (link.ba == MR_CWL) begin
                cwl_code_o <= link.addr[CWL_LSB +: 3];
            end
        end
    end
    assign dll_off_o = mr_ext[DLL_DIS_BIT];

    ////////////////////////////////////////////////////////////////
    // Self refresh: entered by refresh with CKE low, left when CKE rises
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            self_ref_o <= 1'b0;
        end else if (!link.cke && link.cmd == CMD_REF) begin
            self_ref_o <= 1'b1;
        end else if (link.cke) begin
            self_ref_o <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Mode-set delay after each write, counted in clock edges
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mod_cnt <= '0;
        end else if (cmd_mrs) begin
            mod_cnt <= CNT_W'(TMOD_NCK);
        end else if (mod_cnt != '0) begin
            mod_cnt <= mod_cnt - 1'b1;
        end
    end
    assign ready_o = (mod_cnt == '0) && !self_ref_o;

    ////////////////////////////////////////////////////////////////
    // DLL lock: reset by latency register write with reset bit set while the DLL is enabled
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lock_cnt     <= '0;
            dll_locked_o <= 1'b0;
        end else if (cmd_mrs && link.ba == MR_LAT && link.addr[DLL_RST_BIT] && !mr_ext[DLL_DIS_BIT]) begin
            lock_cnt     <= CNT_W'(TDLLK_NCK);
            dll_locked_o <= 1'b0;
        end else if (mr_ext[DLL_DIS_BIT] || self_ref_o) begin
            dll_locked_o <= 1'b0;
        end else if (lock_cnt != '0) begin
            lock_cnt <= lock_cnt - 1'b1;
            if (lock_cnt == CNT_W'(1)) begin
                dll_locked_o <= 1'b1;
            end
        end
    end
endmodule

// *** hdl/dms_ctrl.sv ***
// Controller end: sequencer for DLL-on/off switch through self refresh, APB register slave
`timescale 1ns/1ps
module dms_ctrl
    import dms_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    dms_link_if.ctrl         link
);
    // Register offsets
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_MRVAL  = 8'h08;
    // Control fields
    localparam int CTRL_GO     = 0;
    localparam int CTRL_TO_OFF = 1;
    localparam int CTRL_ZQ     = 2;
    localparam int CTRL_RTT    = 3;

    typedef enum logic [4:0] {
        ST_IDLE    = 5'h00,
        ST_MR_DIS  = 5'h01,
        ST_W_MOD1  = 5'h02,
        ST_SRE     = 5'h03,
        ST_W_CKSRE = 5'h04,
        ST_FCHG    = 5'h05,
        ST_W_CKSRX = 5'h06,
        ST_SRX     = 5'h07,
        ST_W_XS    = 5'h08,
        ST_MR_EN   = 5'h09,
        ST_W_MRD1  = 5'h0A,
        ST_MR_RST  = 5'h0B,
        ST_W_MRD2  = 5'h0C,
        ST_MR_LAT  = 5'h0D,
        ST_W_MRD3  = 5'h0E,
        ST_MR_CWL  = 5'h0F,
        ST_W_MOD2  = 5'h10,
        ST_ZQ      = 5'h11,
        ST_W_ZQ    = 5'h12,
        ST_W_LOCK  = 5'h13,
        ST_DONE    = 5'h14
    } dms_state_type;

    dms_state_type    state;
    dms_state_type    next_state;
    logic [CNT_W-1:0] wait_cnt;
    logic [CNT_W-1:0] next_load;
    logic             load;
    logic [CNT_W-1:0] lock_cnt;
    logic             to_off;
    logic             zq_en;
    logic             rtt_en;
    logic             go;
    logic             done;
    logic [12:0]      mr_base;
    logic             apb_wr;
    logic [3:0]       next_cmd;
    logic [2:0]       next_ba;
    logic [12:0]      next_addr;

    ////////////////////////////////////////////////////////////////
    // APB slave, zero wait states
    assign pready_o  = 1'b1;
    assign apb_wr    = psel_i && penable_i && pwrite_i;
    assign pslverr_o = psel_i && penable_i && paddr_i != REG_CTRL && paddr_i != REG_STATUS
                       && paddr_i != REG_MRVAL;

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            go      <= 1'b0;
            to_off  <= 1'b0;
            zq_en   <= 1'b0;
            rtt_en  <= 1'b0;
            mr_base <= MR_RESET;
        end else begin
            go <= 1'b0;
            if (apb_wr && paddr_i == REG_CTRL) begin
                go <= pwdata_i[CTRL_GO] && state == ST_IDLE;
                if (state == ST_IDLE) begin
                    to_off <= pwdata_i[CTRL_TO_OFF];
                    zq_en  <= pwdata_i[CTRL_ZQ];
                    rtt_en <= pwdata_i[CTRL_RTT];
                end
            end
            if (apb_wr && paddr_i == REG_MRVAL) begin
                mr_base <= pwdata_i[12:0];
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (psel_i && !penable_i) begin
            case (paddr_i)
                REG_CTRL:   prdata_o <= {28'h0, rtt_en, zq_en, to_off, 1'b0};
                REG_STATUS: prdata_o <= {25'h0, state, (lock_cnt == '0), done};
                REG_MRVAL:  prdata_o <= {19'h0, mr_base};
                default:    prdata_o <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // Sequencer: a command cycle plus its wait state together span the whole delay
    always_comb begin
        next_state = state;
        next_load  = '0;
        load       = 1'b0;
        next_cmd   = CMD_NOP;
        next_ba    = 3'h0;
        next_addr  = mr_base;
        case (state)
            ST_IDLE: if (go) next_state = to_off ? ST_MR_DIS : ST_SRE;
            ST_MR_DIS: begin
                next_cmd = CMD_MRS;
                next_ba  = MR_EXT;
                next_addr[DLL_DIS_BIT] = 1'b1;
                next_addr[RTT_BIT0] = 1'b0;
                next_addr[RTT_BIT1] = 1'b0;
                next_addr[RTT_BIT2] = 1'b0;
                next_state = ST_W_MOD1;
                load = 1'b1;
                next_load = CNT_W'(TMOD_NCK - 2);
            end
            ST_W_MOD1:  if (wait_cnt == '0) next_state = ST_SRE;
            ST_SRE: begin
                next_cmd = CMD_REF;
                next_state = ST_W_CKSRE;
                load = 1'b1;
                next_load = CNT_W'(TCKSRE_NCK - 1);
            end
            ST_W_CKSRE: if (wait_cnt == '0) next_state = ST_FCHG;
            ST_FCHG: begin
                next_state = ST_W_CKSRX;
                load = 1'b1;
                next_load = CNT_W'(TCKSRX_NCK - 1);
            end
            ST_W_CKSRX: if (wait_cnt == '0) next_state = ST_SRX;
            ST_SRX: begin
                next_state = ST_W_XS;
                load = 1'b1;
                next_load = CNT_W'(TXS_NCK - 1);
            end
            ST_W_XS: if (wait_cnt == '0) next_state = to_off ? ST_MR_LAT : ST_MR_EN;
            ST_MR_EN: begin
                next_cmd = CMD_MRS;
                next_ba  = MR_EXT;
                next_addr[DLL_DIS_BIT] = 1'b0;
                next_state = ST_W_MRD1;
                load = 1'b1;
                next_load = CNT_W'(TMRD_NCK - 2);
            end
            ST_W_MRD1: if (wait_cnt == '0) next_state = ST_MR_RST;
            ST_MR_RST: begin
                next_cmd = CMD_MRS;
                next_ba  = MR_LAT;
                next_addr[DLL_RST_BIT] = 1'b1;
                next_state = ST_W_MRD2;
                load = 1'b1;
                next_load = CNT_W'(TMRD_NCK - 2);
            end
            ST_W_MRD2: if (wait_cnt == '0) next_state = ST_MR_LAT;
            ST_MR_LAT: begin
                next_cmd = CMD_MRS;
                next_ba  = MR_LAT;
                next_addr[DLL_RST_BIT] = 1'b0;
                if (to_off) next_addr[CL_LSB +: 3] = CL6_CODE;
                next_state = ST_W_MRD3;
                load = 1'b1;
                next_load = CNT_W'(TMRD_NCK - 2);
            end
            ST_W_MRD3: if (wait_cnt == '0) next_state = ST_MR_CWL;
            ST_MR_CWL: begin
                next_cmd = CMD_MRS;
                next_ba  = MR_CWL;
                next_addr[CWL_LSB +: 3] = to_off ? CWL6_CODE : mr_base[CWL_LSB +: 3];
                next_state = ST_W_MOD2;
                load = 1'b1;
                next_load = CNT_W'(TMOD_NCK - 2);
            end
            ST_W_MOD2: if (wait_cnt == '0) next_state = zq_en ? ST_ZQ : ST_W_LOCK;
            ST_ZQ: begin
                next_cmd = CMD_ZQ;
                next_addr = 13'h0400;
                next_state = ST_W_ZQ;
                load = 1'b1;
                next_load = CNT_W'(TZQOPER_NCK - 2);
            end
            ST_W_ZQ:   if (wait_cnt == '0) next_state = ST_W_LOCK;
            ST_W_LOCK: if (to_off || lock_cnt == '0) next_state = ST_DONE;
            ST_DONE:   next_state = ST_IDLE;
            default:   next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wait_cnt <= '0;
        end else if (load) begin
            wait_cnt <= next_load;
        end else if (wait_cnt != '0) begin
            wait_cnt <= wait_cnt - 1'b1;
        end
    end

    // Lock timer started by the DLL reset write
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lock_cnt <= '0;
        end else if (state == ST_MR_RST) begin
            lock_cnt <= CNT_W'(TDLLK_NCK);
        end else if (lock_cnt != '0) begin
            lock_cnt <= lock_cnt - 1'b1;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            done <= 1'b0;
        end else if (state == ST_DONE) begin
            done <= 1'b1;
        end else if (go) begin
            done <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Pin drive, registered
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            link.cmd        <= CMD_NOP;
            link.ba         <= 3'h0;
            link.addr       <= 13'h0000;
            link.cke        <= 1'b1;
            link.odt        <= 1'b0;
            link.clk_change <= 1'b0;
        end else begin
            link.cmd  <= next_cmd;
            link.ba   <= next_ba;
            link.addr <= next_addr;
            // CKE falls with the entry command, so no idle cycle reads as power-down
            link.cke  <= !(next_state inside {ST_W_CKSRE, ST_FCHG, ST_W_CKSRX});
            link.odt  <= 1'b0;
            link.clk_change <= (next_state == ST_FCHG);
        end
    end
endmodule

// *** verification/dms_link_asserts.sv ***
// Checker: timing relations on the pins between controller and memory
`timescale 1ns/1ps
module dms_link_asserts
    import dms_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    input  wire logic        cke,
    input  wire logic        odt,
    input  wire logic [3:0]  cmd,
    input  wire logic [2:0]  ba,
    input  wire logic [12:0] addr,
    input  wire logic        clk_change
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    logic is_mrs;
    assign is_mrs = (cmd == CMD_MRS) && cke;
    ////////////////////////////////////////////////////////////////////////
    chk_odt_held_low: assert property (odt == 1'b0)
        else $error("odt driven high");
    chk_mrs_spacing: assert property (is_mrs |=> !is_mrs [*3])
        else $error("mode writes closer than four cycles");
    chk_disable_wait: assert property (is_mrs && ba == MR_EXT && addr[DLL_DIS_BIT]
        |-> not (##[1:11] cmd == CMD_REF))
        else $error("self refresh too soon after DLL disable");
    chk_sr_hold: assert property (cmd == CMD_REF && !cke |=> !cke [*5])
        else $error("clock enable rose too soon after self refresh entry");
    chk_change_in_sr: assert property (clk_change |-> !cke && !$past(cke, 5))
        else $error("frequency change outside settled self refresh");
    chk_stable_before_exit: assert property (clk_change |=> !cke [*4])
        else $error("self refresh exit too soon after frequency change");
    chk_cke_hold: assert property ($rose(cke) |-> cke [*8])
        else $error("clock enable dropped after exit");
    chk_exit_wait: assert property ($rose(cke) |-> !is_mrs [*4])
        else $error("mode write within exit delay");
    chk_dll_reset_order: assert property (is_mrs && ba == MR_EXT && !addr[DLL_DIS_BIT]
        |-> ##4 (is_mrs && ba == MR_LAT && addr[DLL_RST_BIT]))
        else $error("DLL reset write missing after enable");
    chk_final_mode_wait: assert property (is_mrs && ba == MR_CWL
        |-> not (##[1:11] (cmd != CMD_NOP && cmd != CMD_DES)))
        else $error("command within mode delay after last write");
    cover property (clk_change);
    cover property (is_mrs && ba == MR_EXT && addr[DLL_DIS_BIT]);
    cover property (cmd == CMD_ZQ);
endmodule

// *** verification/tb_ddr3_dll_mode_switch_sequence.sv ***
// Testbench: both ends joined, switch sequences driven over APB
`timescale 1ns/1ps
module tb_ddr3_dll_mode_switch_sequence;
    import dms_pkg::*;
    logic        mclk_i = 0, rst_n_i = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err, dll_off, locked, self_ref, ready;
    logic [2:0]  cl, cwl;
    int          n_fail = 0, tests_run = 0, cyc = 0, n_chg, t_ref, t_done, zq_ad, sr_chg;
    int          q_ba[$], q_ad[$], q_t[$], e_ba[$];
    dms_link_if link ();
    dms_ctrl dms_ctrl_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .link(link));
    dms_mem dms_mem_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .link(link), .dll_off_o(dll_off), .dll_locked_o(locked),
        .self_ref_o(self_ref), .ready_o(ready), .cl_code_o(cl), .cwl_code_o(cwl));
    dms_link_asserts dms_link_asserts_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .cke(link.cke), .odt(link.odt),
        .cmd(link.cmd), .ba(link.ba), .addr(link.addr), .clk_change(link.clk_change));
    initial begin
        forever #25 mclk_i = ~mclk_i;
    end
    ////////////////////////////////////////////////////////////////////////
    // Pin monitor: logs mode writes, self refresh entry and frequency changes
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc > 20000) begin
            n_fail++;
            test_done();
        end
        if (link.cmd === CMD_MRS && link.cke === 1'b1) begin
            q_ba.push_back(link.ba);
            q_ad.push_back(link.addr);
            q_t.push_back(cyc);
        end
        if (link.cmd === CMD_REF && link.cke === 1'b0) t_ref = cyc;
        if (link.cmd === CMD_ZQ) zq_ad = link.addr;
        if (link.clk_change === 1'b1) begin
            n_chg++;
            sr_chg = (self_ref === 1'b1);
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk_i);
        penable <= 1'b1;
        do @(posedge mclk_i); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic run_switch(input bit to_off, input bit zq);
        q_ba = {};
        q_ad = {};
        q_t = {};
        n_chg = 0;
        zq_ad = 0;
        sr_chg = 0;
        if (to_off) e_ba = {MR_EXT, MR_LAT, MR_CWL};
        else e_ba = {MR_EXT, MR_LAT, MR_LAT, MR_CWL};
        apb(1'b1, 8'h00, {28'h0, 1'b1, zq, to_off, 1'b1});
        apb(1'b1, 8'h00, {28'h0, 1'b1, zq, ~to_off, 1'b1});
        rd = 32'h0;
        while (rd[0] !== 1'b1) apb(1'b0, 8'h04, 32'h0);
        t_done = cyc;
        chk("mrs count", e_ba.size(), q_ba.size());
        foreach (e_ba[i]) chk("mrs select", e_ba[i], (i < q_ba.size()) ? q_ba[i] : -1);
        chk("freq changes", 1, n_chg);
        chk("sr at change", 1, sr_chg);
        chk("self ref left", 0, self_ref);
        chk("dll off", to_off, dll_off);
        chk("ready", 1, ready);
        chk("zq addr", zq ? 32'h400 : 32'h0, zq_ad);
        if (q_t.size() != e_ba.size()) return;
        chk("dll bit", to_off, q_ad[0] & 1);
        if (to_off) begin
            chk("disable to sr", TMOD_NCK, t_ref - q_t[0]);
            chk("lat to cwl", TMRD_NCK, q_t[2] - q_t[1]);
            chk("cl code", CL6_CODE, cl);
            chk("cwl code", CWL6_CODE, cwl);
        end else begin
            chk("enable to reset", TMRD_NCK, q_t[1] - q_t[0]);
            chk("reset bit", 1, (q_ad[1] >> DLL_RST_BIT) & 1);
            chk("lock wait", 1, (t_done - q_t[1]) >= TDLLK_NCK);
            chk("locked", 1, locked);
        end
        $display("switch to_off=%0d zq=%0d finished", to_off, zq);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] mv;
        void'($urandom(95));
        repeat (20) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        chk("reset cmd", CMD_NOP, link.cmd);
        chk("reset cke", 1, link.cke);
        chk("reset dll off", 0, dll_off);
        $display("reset test finished");
        mv = $urandom & 32'h1C82;
        apb(1'b1, 8'h08, mv);
        apb(1'b0, 8'h08, 32'h0);
        chk("mrval", mv, rd);
        apb(1'b0, 8'h3C, 32'h0);
        chk("unmapped err", 1, err);
        chk("unmapped data", 0, rd);
        $display("register test finished");
        run_switch(1'b1, 1'($urandom));
        apb(1'b0, 8'h00, 32'h0);
        chk("rtt readback", 1, rd[3]);
        run_switch(1'b0, 1'b1);
        run_switch(1'b1, 1'b0);
        test_done();
    end
endmodule
